// File: include/smc_pkg.sv
// smc_pkg: register map, field positions and reset values of the supply monitor block
// assumes a byte-wide register port with addresses up to 16 bits
package smc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [15:0] ADDR_BATTERY_CONTROL  = 16'h285C;
	localparam logic [15:0] ADDR_COMP_BIAS_INSEL  = 16'h2861;
	localparam logic [15:0] ADDR_COMP_ENABLE_CTRL = 16'h2864;
	localparam logic [15:0] ADDR_REGULATOR_CTRL   = 16'h2866;
	localparam logic [15:0] ADDR_ANALOG_STATE     = 16'h286B;
	localparam logic [15:0] ADDR_EXT_IRQ_FLAG     = 16'h28A2;
	localparam logic [15:0] ADDR_EXT_IRQ_ENABLE   = 16'h28A5;
	localparam logic [15:0] ADDR_SYSTEM_STATE     = 16'h00A1;
	localparam logic [15:0] ADDR_GLOBAL_IRQ_EN    = 16'h00A8;
	localparam logic [15:0] ADDR_EXT_GROUP_IRQ_EN = 16'h00E8;
	localparam logic [15:0] ADDR_POWER_IRQ_MASK   = 16'h28F0;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_DETECTOR_DISABLE = 7;
	localparam int BIT_ANALOG_LVL_LO    = 3;
	localparam int BIT_DIGITAL_LVL_LO   = 0;
	localparam int LVL_W                = 3;
	localparam int BIT_POWER_DOWN       = 1;
	localparam int BIT_LINE_POWERED     = 0;
	localparam int BIT_BATTERY_DISCH    = 0;
	localparam int BIT_COMP_IRQ         = 6;
	localparam int BIT_EXT_GROUP_EN     = 3;
	localparam int BIT_GLOBAL_EN        = 7;
	localparam int BIT_COMP_RESULT      = 5;
	localparam int BIT_COMP_BIAS        = 4;
	localparam int BIT_COMP_INSEL_LO    = 2;
	localparam int INSEL_W              = 2;
	localparam int BIT_COMP_ENABLE      = 5;

	// ----------------------------------------
	// reset values and encodings
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [2:0] RST_LEVEL   = 3'h0;
	localparam logic [1:0] SEL_M2_REF  = 2'h0;
	localparam logic [1:0] SEL_M1_REF  = 2'h1;
	localparam logic [1:0] SEL_M2_M1   = 2'h2;
endpackage

// File: rtl/smc_ctrl.sv
// smc_ctrl: control, status and interrupt logic around supply monitor and comparator
// assumes analog supervisor/comparator outputs arrive asynchronously; single mclk domain
//
// Behaviour
// R1: detector disable bit, resets enabled
// R2: analog regulator level field drives output
// R3: digital regulator level field drives output
// R4: line below 1 V sets power-down, interrupts
// R5: line-powered flag low below 1.0 V
// R6: discharge bit switches 3 mA load
// R7: software keeps discharge brief, clears it
// R8: comparator halted by resets and sleep
// R9: comparator interrupt needs three enables
// R10: any comparator output change sets flag
// R11: comparator result bit, positive above negative
// R12: input select routes comparator pins
// R13: bias select picks 20/200 nA
// R14: comparator enable bit powers comparator
// R15: line-powered set only above 1.1 V
// R16: power-down stays clear above 1.1 V
// R17: comparator flag sticky until software clears
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module smc_ctrl
	import smc_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// register port
	input  wire logic [smc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [smc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [smc_pkg::DATA_W-1:0] reg_rdata,
	// supervisor and comparator inputs (asynchronous)
	input  wire logic                   line_below_low,
	input  wire logic                   line_above_high,
	input  wire logic                   comparator_out,
	// system state
	input  wire logic                   level1_reset,
	input  wire logic                   sleep_state,
	// analog controls
	output logic                        detector_disable,
	output logic      [2:0]             analog_reg_level_sel,
	output logic      [2:0]             digital_reg_level_sel,
	output logic                        battery_discharge,
	output logic                        comparator_enable,
	output logic                        comparator_bias_select,
	output logic      [1:0]             comparator_input_select,
	// interrupts
	output logic                        power_down_irq,
	output logic                        comparator_irq,
	output logic                        irq
);
	import smc_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// analog levels change at any moment; only sync_q is read by logic,
	// so a metastable first stage never reaches a flag
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
		end else begin
			meta_q <= {comparator_out, line_above_high, line_below_low};
			sync_q <= meta_q;
		end
	end
	logic low_s, high_s, cmp_s;
	assign low_s  = sync_q[0];
	assign high_s = sync_q[1];
	assign cmp_s  = sync_q[2];

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	// one address compare shared by every strobe and every clear
	function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] target);
		return a == target;
	endfunction

	// ----------------------------------------
	// write strobes, one per register
	// ----------------------------------------
	// unmapped addresses match no strobe, so their writes are dropped
	logic we_reg_ctrl, we_bat, we_bias, we_cen;
	logic we_ext_en, we_grp_en, we_glb_en, we_pmask;
	assign we_reg_ctrl = reg_wr && wr_hit(reg_addr, ADDR_REGULATOR_CTRL);
	assign we_bat      = reg_wr && wr_hit(reg_addr, ADDR_BATTERY_CONTROL);
	assign we_bias     = reg_wr && wr_hit(reg_addr, ADDR_COMP_BIAS_INSEL);
	assign we_cen      = reg_wr && wr_hit(reg_addr, ADDR_COMP_ENABLE_CTRL);
	assign we_ext_en   = reg_wr && wr_hit(reg_addr, ADDR_EXT_IRQ_ENABLE);
	assign we_grp_en   = reg_wr && wr_hit(reg_addr, ADDR_EXT_GROUP_IRQ_EN);
	assign we_glb_en   = reg_wr && wr_hit(reg_addr, ADDR_GLOBAL_IRQ_EN);
	assign we_pmask    = reg_wr && wr_hit(reg_addr, ADDR_POWER_IRQ_MASK);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// detector stays on after reset; boards on a 3.3 V supply must turn it off
	// no discharge timeout here: software alone keeps the load brief
	logic [7:0] reg_ctrl_q, bat_q, bias_q, cen_q, ext_en_q, grp_en_q, glb_en_q, pmask_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_ctrl_q <= RST_BYTE; // [R1]
		end else if (we_reg_ctrl) begin
			reg_ctrl_q <= reg_wdata; // [R1] [R2] [R3]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bat_q <= RST_BYTE;
		end else if (we_bat) begin
			bat_q <= reg_wdata; // [R6]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bias_q <= RST_BYTE; // [R13]
		end else if (we_bias) begin
			bias_q <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cen_q <= RST_BYTE; // [R14]
		end else if (we_cen) begin
			cen_q <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_en_q <= RST_BYTE;
		end else if (we_ext_en) begin
			ext_en_q <= reg_wdata; // [R9]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			grp_en_q <= RST_BYTE;
		end else if (we_grp_en) begin
			grp_en_q <= reg_wdata; // [R9]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			glb_en_q <= RST_BYTE;
		end else if (we_glb_en) begin
			glb_en_q <= reg_wdata; // [R9]
		end
	end

	// power-down interrupt stays off until software opts in
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pmask_q <= RST_BYTE;
		end else if (we_pmask) begin
			pmask_q <= reg_wdata; // [R4]
		end
	end

	// ----------------------------------------
	// supervisor flags
	// ----------------------------------------
	// hysteresis: set above 1.1 V only, clear below 1.0 V only
	logic line_powered_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			line_powered_q <= 1'b0;
		end else if (low_s) begin
			line_powered_q <= 1'b0; // [R5]
		end else if (high_s) begin
			line_powered_q <= 1'b1; // [R15]
		end
	end

	// power-down follows supervisor; detector off freezes it clear
	logic power_down_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			power_down_q <= 1'b0;
		end else if (reg_ctrl_q[BIT_DETECTOR_DISABLE]) begin
			power_down_q <= 1'b0; // [R1]
		end else if (low_s) begin
			power_down_q <= 1'b1; // [R4]
		end else if (high_s) begin
			power_down_q <= 1'b0; // [R16]
		end
	end

	// ----------------------------------------
	// comparator
	// ----------------------------------------
	// halt gates the run enable directly, so the comparator stops in the same cycle
	logic cmp_run;
	assign cmp_run = cen_q[BIT_COMP_ENABLE] && !level1_reset && !sleep_state; // [R8] [R14]

	logic cmp_result_q, cmp_valid_q;
	// result clears while halted so a stale level never reads back
	always_ff @(posedge mclk) begin
		if (sys_rst || !cmp_run) begin
			cmp_result_q <= 1'b0; // [R8] [R11]
		end else begin
			cmp_result_q <= cmp_s; // [R11]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || !cmp_run) begin
			cmp_valid_q <= 1'b0; // [R8]
		end else begin
			cmp_valid_q <= 1'b1;
		end
	end

	// first sample after restart is a baseline, not a change
	logic cmp_change;
	assign cmp_change = cmp_run && cmp_valid_q && (cmp_s != cmp_result_q); // [R10]

	// ----------------------------------------
	// sticky flags, write one to clear
	// ----------------------------------------
	logic clr_ext, clr_sys;
	assign clr_ext = reg_wr && wr_hit(reg_addr, ADDR_EXT_IRQ_FLAG);
	assign clr_sys = reg_wr && wr_hit(reg_addr, ADDR_SYSTEM_STATE);

	// a change and a clear in one cycle keep the flag set, so no edge is lost
	logic cmp_flag_q, cmp_flag_d;
	always_comb begin
		cmp_flag_d = cmp_flag_q;
		if (cmp_change) begin
			cmp_flag_d = 1'b1; // [R10] set beats clear
		end else if (clr_ext && reg_wdata[BIT_COMP_IRQ]) begin
			cmp_flag_d = 1'b0; // [R17]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmp_flag_q <= 1'b0;
		end else begin
			cmp_flag_q <= cmp_flag_d;
		end
	end

	// power-down event latch for the interrupt; the status bit follows the supervisor
	logic pd_prev_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pd_prev_q <= 1'b0;
		end else begin
			pd_prev_q <= power_down_q;
		end
	end

	logic pd_rise;
	assign pd_rise = power_down_q && !pd_prev_q;

	logic pd_evt_q, pd_evt_d;
	always_comb begin
		pd_evt_d = pd_evt_q;
		if (pd_rise) begin
			pd_evt_d = 1'b1; // [R4] set beats clear
		end else if (clr_sys && reg_wdata[BIT_POWER_DOWN]) begin
			pd_evt_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pd_evt_q <= 1'b0;
		end else begin
			pd_evt_q <= pd_evt_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign detector_disable        = reg_ctrl_q[BIT_DETECTOR_DISABLE]; // [R1]
	assign analog_reg_level_sel    = reg_ctrl_q[BIT_ANALOG_LVL_LO +: LVL_W]; // [R2]
	assign digital_reg_level_sel   = reg_ctrl_q[BIT_DIGITAL_LVL_LO +: LVL_W]; // [R3]
	assign battery_discharge       = bat_q[BIT_BATTERY_DISCH]; // [R6]
	assign comparator_enable       = cmp_run; // [R8] [R14]
	assign comparator_bias_select  = bias_q[BIT_COMP_BIAS]; // [R13]
	assign comparator_input_select = bias_q[BIT_COMP_INSEL_LO +: INSEL_W]; // [R12]

	// ----------------------------------------
	// interrupt outputs
	// ----------------------------------------
	// one level line; each source keeps its own gate so either can be told apart
	assign comparator_irq = cmp_flag_q && ext_en_q[BIT_COMP_IRQ]
		&& grp_en_q[BIT_EXT_GROUP_EN] && glb_en_q[BIT_GLOBAL_EN]; // [R9]
	assign power_down_irq = pd_evt_q && pmask_q[BIT_POWER_DOWN]; // [R4]
	assign irq            = comparator_irq || power_down_irq;

	// ----------------------------------------
	// read port
	// ----------------------------------------
	logic [7:0] rd_d;
	always_comb begin
		rd_d = RST_BYTE;
		case (reg_addr)
			ADDR_REGULATOR_CTRL:   rd_d = reg_ctrl_q;
			ADDR_BATTERY_CONTROL:  rd_d = bat_q;
			ADDR_COMP_BIAS_INSEL:  rd_d = bias_q;
			ADDR_COMP_ENABLE_CTRL: rd_d = cen_q;
			ADDR_EXT_IRQ_ENABLE:   rd_d = ext_en_q;
			ADDR_EXT_GROUP_IRQ_EN: rd_d = grp_en_q;
			ADDR_GLOBAL_IRQ_EN:    rd_d = glb_en_q;
			ADDR_POWER_IRQ_MASK:   rd_d = pmask_q;
			// a halted comparator reads 0 even in the cycle the halt begins
			ADDR_ANALOG_STATE:     rd_d[BIT_COMP_RESULT] = cmp_result_q && cmp_run; // [R11]
			ADDR_EXT_IRQ_FLAG:     rd_d[BIT_COMP_IRQ] = cmp_flag_q; // [R17]
			ADDR_SYSTEM_STATE: begin
				rd_d[BIT_POWER_DOWN]   = power_down_q; // [R4]
				rd_d[BIT_LINE_POWERED] = line_powered_q; // [R5]
			end
			default:               rd_d = RST_BYTE;
		endcase
	end

	// data stands one cycle only; zero between reads so nothing stale lingers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= rd_d;
		end else begin
			reg_rdata <= RST_BYTE;
		end
	end
endmodule

// File: test/smc_ctrl_props.sv
// smc_ctrl_props: port-level checks for smc_ctrl
// assumes binding into smc_ctrl, one mclk domain
`timescale 1ns/1ps
module smc_ctrl_props (
	// clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// state and outputs
	input wire logic        level1_reset,
	input wire logic        sleep_state,
	input wire logic        detector_disable,
	input wire logic [2:0]  analog_reg_level_sel,
	input wire logic [2:0]  digital_reg_level_sel,
	input wire logic        battery_discharge,
	input wire logic        comparator_enable,
	input wire logic        power_down_irq,
	input wire logic        comparator_irq,
	input wire logic        irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	reg_ctl_a: assert property (
		reg_wr && reg_addr == 16'h2866 |=> {detector_disable, analog_reg_level_sel,
		digital_reg_level_sel} == {$past(reg_wdata[7]), $past(reg_wdata[5:0])})
		else $error("regulator control mismatch");
	disch_wr_a: assert property (
		reg_wr && reg_addr == 16'h285C |=> battery_discharge == $past(reg_wdata[0]))
		else $error("discharge bit mismatch");
	comp_halt_a: assert property (
		level1_reset || sleep_state |-> !comparator_enable)
		else $error("comparator runs while halted");
	irq_join_a: assert property (
		irq == (comparator_irq || power_down_irq))
		else $error("combined interrupt mismatch");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	flag_sticky_a: assert property (
		comparator_irq && !reg_wr |=> comparator_irq)
		else $error("comparator interrupt dropped");
	flag_run_a: assert property (
		$rose(comparator_irq) |-> $past(reg_wr) || $past(comparator_enable))
		else $error("comparator flag set while halted");
	pd_detect_a: assert property (
		$rose(power_down_irq) && !$past(reg_wr) |-> !$past(detector_disable))
		else $error("power-down with detector off");
	halt_result_a: assert property (
		reg_rd && reg_addr == 16'h286B && !comparator_enable |=> !reg_rdata[5])
		else $error("result bit set while halted");
endmodule

// File: test/smc_ctrl_tb_top.sv
// smc_ctrl_tb_top: self-checking bench for smc_ctrl
// assumes smc_pkg and smc_ctrl_props compiled first
`timescale 1ns/1ps
module smc_ctrl_tb_top;
	logic        mclk, sys_rst, reg_wr, reg_rd, lo, hi, cmp, l1r, slp;
	logic        dd, bd, ce, bs, pdi, ci, irq;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [2:0]  als, dls;
	logic [1:0]  isel;
	int          fails, compares, seed, i;
	int          rw [4] = '{'h285C, 'h2861, 'h2864, 'h2866};
	logic [7:0]  m [int];
	smc_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_below_low(lo),
		.line_above_high(hi), .comparator_out(cmp), .level1_reset(l1r), .sleep_state(slp),
		.detector_disable(dd), .analog_reg_level_sel(als), .digital_reg_level_sel(dls),
		.battery_discharge(bd), .comparator_enable(ce), .comparator_bias_select(bs),
		.comparator_input_select(isel), .power_down_irq(pdi), .comparator_irq(ci), .irq(irq));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		if (m.exists(a))
			m[a] = v;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk("rdata", reg_rdata, e);
	endtask
	// async inputs need three edges to reach the flags
	task automatic drive(input logic h, l, c, s, r);
		@(posedge mclk);
		{hi, lo, cmp, slp, l1r} <= {h, l, c, s, r};
		repeat (4) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic give_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#2000000;
		fails++;
		give_verdict;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{sys_rst, reg_wr, reg_rd, lo, hi, cmp, l1r, slp} = 8'h80;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		seed = 92;
		foreach (rw[k]) m[rw[k]] = 8'h00;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (rw[k]) rd(rw[k][15:0], 8'h00);
		rd(16'h286B, 8'h00);
		rd(16'h00A1, 8'h00);
		for (i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			wr(rw[i % 4][15:0], d);
			rd(rw[i % 4][15:0], m[rw[i % 4]]);
			chk("ldo", {dd, 1'b0, als, dls}, m['h2866] & 8'hBF);
			chk("bias", {5'h0, bs, isel}, {5'h0, m['h2861][4:2]});
			chk("en", {7'h0, ce}, {7'h0, m['h2864][5]});
		end
		wr(16'h1234, 8'hFF);
		rd(16'h1234, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(16'h2861, 8'(i << 2));
			chk("sel", {6'h0, isel}, 8'(i));
		end
		wr(16'h285C, 8'h01);
		chk("disc", {7'h0, bd}, 8'h01);
		wr(16'h285C, 8'h00);
		chk("disc", {7'h0, bd}, 8'h00);
		wr(16'h2866, 8'h00);
		wr(16'h28F0, 8'h02);
		drive(1, 0, 0, 0, 0);
		rd(16'h00A1, 8'h01);
		drive(0, 1, 0, 0, 0);
		rd(16'h00A1, 8'h02);
		chk("pirq", {6'h0, pdi, irq}, 8'h03);
		drive(1, 0, 0, 0, 0);
		wr(16'h00A1, 8'h02);
		@(negedge mclk);
		chk("pirq", {7'h0, pdi}, 8'h00);
		wr(16'h2866, 8'h80);
		drive(0, 1, 0, 0, 0);
		rd(16'h00A1, 8'h00);
		drive(1, 0, 0, 0, 0);
		wr(16'h2866, 8'h00);
		wr(16'h2864, 8'h20);
		wr(16'h28A5, 8'h40);
		wr(16'h00E8, 8'h08);
		wr(16'h00A8, 8'h80);
		drive(1, 0, 1, 0, 0);
		chk("cirq", {6'h0, ci, irq}, 8'h03);
		rd(16'h28A2, 8'h40);
		rd(16'h286B, 8'h20);
		chk("cirq", {7'h0, ci}, 8'h01);
		wr(16'h28A2, 8'h40);
		@(negedge mclk);
		chk("cirq", {7'h0, ci}, 8'h00);
		wr(16'h00A8, 8'h00);
		drive(1, 0, 0, 0, 0);
		chk("cirq", {7'h0, ci}, 8'h00);
		rd(16'h28A2, 8'h40);
		rd(16'h286B, 8'h00);
		wr(16'h28A2, 8'h40);
		drive(1, 0, 1, 1, 0);
		chk("en", {7'h0, ce}, 8'h00);
		rd(16'h28A2, 8'h00);
		rd(16'h286B, 8'h00);
		drive(1, 0, 1, 0, 1);
		chk("en", {7'h0, ce}, 8'h00);
		rd(16'h28A2, 8'h00);
		drive(1, 0, 1, 0, 0);
		rd(16'h28A2, 8'h00);
		rd(16'h286B, 8'h20);
		give_verdict;
	end
endmodule
bind smc_ctrl smc_ctrl_props u_props (.*);
